// File: hw/cnl_pkg.sv
// cnl_pkg: shared constants and types of the canopen node block
// assumes a 200 MHz hclk and a 32-bit ahb-lite register bus
package cnl_pkg;
	// ====================================================
	// bus register offsets
	localparam logic [7:0] R_TTYPE  = 8'h00; // tpdo transmission type
	localparam logic [7:0] R_EVT    = 8'h04; // tpdo event timer, ms
	localparam logic [7:0] R_SERIAL = 8'h08; // serial number
	localparam logic [7:0] R_ST0    = 8'h0C; // status word zero
	localparam logic [7:0] R_ST1    = 8'h10; // status word one
	localparam logic [7:0] R_QUES   = 8'h14; // questionable status
	localparam logic [7:0] R_MCUR   = 8'h18; // measured current
	localparam logic [7:0] R_MVOLT  = 8'h1C; // measured voltage
	localparam logic [7:0] R_MPWR   = 8'h20; // measured power
	localparam logic [7:0] R_INFO   = 8'h24; // node state, read only
	// info register field positions
	localparam int F_NMT = 0;
	localparam int F_CFG = 2;
	localparam int F_BT  = 4;
	localparam int F_ID  = 8;
	// ====================================================
	// node defaults and limits
	localparam logic [6:0] DEF_ID   = 7'h70;
	localparam logic [3:0] DEF_BT   = 4'h8;
	localparam logic [3:0] BT_MAX   = 4'h8;
	localparam logic [7:0] ID_MIN   = 8'h01;
	localparam logic [7:0] ID_MAX   = 8'h7F;
	localparam logic [7:0] TT_SYNC  = 8'h01;
	localparam logic [7:0] TT_EVENT = 8'hFF;
	// timing
	localparam int CLK_NS = 5;
	localparam int MS_NS  = 1000000;
	localparam int MS_CYC = MS_NS / CLK_NS;
	// ====================================================
	// dictionary areas
	localparam logic [15:0] A_TYP_LO = 16'h0001;
	localparam logic [15:0] A_TYP_HI = 16'h025F;
	localparam logic [15:0] A_COM_LO = 16'h1000;
	localparam logic [15:0] A_MFR_LO = 16'h2000;
	localparam logic [15:0] A_DEV_LO = 16'h6000;
	localparam logic [15:0] A_IFC_LO = 16'hA000;
	localparam logic [15:0] A_RSV_LO = 16'hC000;
	// fixed objects
	localparam logic [15:0] X_NONE  = 16'h0000;
	localparam logic [15:0] X_QUES  = 16'h200B;
	localparam logic [15:0] X_STAT  = 16'h200D;
	localparam logic [15:0] X_MCUR  = 16'h2101;
	localparam logic [15:0] X_MVOLT = 16'h2102;
	localparam logic [15:0] X_MPWR  = 16'h2103;
	localparam logic [15:0] X_TPC   = 16'h1800;
	localparam logic [7:0]  SUB_ST0 = 8'h01;
	localparam logic [7:0]  SUB_ST1 = 8'h02;
	localparam logic [7:0]  SUB_TT  = 8'h02;
	localparam logic [7:0]  SUB_EVT = 8'h05;
	// ====================================================
	// stored objects: slot i is written at W_IDX[i], read at R_IDX[i]; slot S_FACT only triggers a reload and has no read index
	localparam int OBJ_N  = 20;
	localparam int S_OUT  = 0;
	localparam int S_CUR  = 1;
	localparam int S_LOCK = 15;
	localparam int S_FACT = 19;
	localparam logic [15:0] W_IDX [OBJ_N] = '{16'h200F, 16'h2201, 16'h2203, 16'h2205,
		16'h2301, 16'h2303, 16'h2305, 16'h2307, 16'h2401, 16'h2403, 16'h2405, 16'h2409,
		16'h240B, 16'h240D, 16'h2503, 16'h2703, 16'h2706, 16'h2708, 16'h270A, 16'h2701};
	localparam logic [15:0] R_IDX [OBJ_N] = '{16'h2010, 16'h2202, 16'h2204, 16'h2206,
		16'h2302, 16'h2304, 16'h2306, 16'h2308, 16'h2402, 16'h2404, 16'h2406, 16'h240A,
		16'h240C, 16'h240E, 16'h2504, 16'h2702, 16'h2707, 16'h2709, 16'h270B, 16'h0000};
	// ====================================================
	// types
	typedef enum logic [1:0] {N_INIT, N_PREOP, N_OPER, N_STOP} cnl_nmt_t;
	typedef enum logic [2:0] {L_SW_GLOBAL, L_SW_SEL, L_CFG_ID, L_CFG_BIT, L_STORE} cnl_lss_t;
	typedef enum logic [2:0] {AR_RSV, AR_TYP, AR_COM, AR_MFR, AR_DEV, AR_IFC} cnl_area_t;
	localparam logic [1:0] NC_START = 2'h0;
	localparam logic [1:0] NC_STOP  = 2'h1;
	localparam logic [1:0] NC_PREOP = 2'h2;
	localparam logic [1:0] NC_RESET = 2'h3;
endpackage

// File: hw/cnl_node.sv
// cnl_node: canopen slave node logic, lss, sdo dictionary and tpdo timing
// assumes decoded can frames arrive as one-cycle strobes on hclk
`timescale 1ns/1ps
module cnl_node #(
	parameter logic [31:0] VENDOR_ID    = 32'h0000_0A01, // arbitrary value
	parameter logic [31:0] PRODUCT_CODE = 32'h0000_0B02, // arbitrary value
	parameter logic [31:0] REVISION     = 32'h0000_0C03, // arbitrary value
	parameter int          MS_CYCLES    = cnl_pkg::MS_CYC
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	input  wire logic              nmt_valid,
	input  wire logic [1:0]        nmt_cmd,
	input  wire logic              lss_valid,
	input  wire cnl_pkg::cnl_lss_t lss_cmd,
	input  wire logic [7:0]        lss_arg,
	input  wire logic [31:0]       lss_vendor,
	input  wire logic [31:0]       lss_product,
	input  wire logic [31:0]       lss_revision,
	input  wire logic [31:0]       lss_serial,
	input  wire logic              sdo_valid,
	input  wire logic              sdo_write,
	input  wire logic [15:0]       sdo_index,
	input  wire logic [7:0]        sdo_sub,
	input  wire logic [31:0]       sdo_wdata,
	input  wire logic              sync_pulse,
	input  wire logic              event_pulse,
	output logic                   sdo_resp_valid,
	output logic                   sdo_resp_abort,
	output logic [31:0]            sdo_rdata,
	output logic [2:0]             sdo_area,
	output logic                   lss_resp_valid,
	output logic                   lss_resp_err,
	output logic                   lss_config,
	output logic [1:0]             nmt_state,
	output logic [6:0]             node_id,
	output logic [3:0]             bit_timing,
	output logic [9:0]             bit_rate_kbps,
	output logic                   store_pulse,
	output logic                   factory_reload,
	output logic                   tpdo_send,
	output logic                   output_on
);
	import cnl_pkg::*;

	localparam int TW = $clog2(MS_CYCLES + 1);

	// ====================================================
	// state of the whole node
	typedef struct packed {
		cnl_nmt_t                nmt;
		logic                    cfg;
		logic [6:0]              id;
		logic [6:0]              pid;
		logic [6:0]              nid;
		logic [3:0]              bt;
		logic [3:0]              pbt;
		logic [3:0]              nbt;
		logic [9:0]              kbps;
		logic [7:0]              ttype;
		logic [15:0]             evt;
		logic [31:0]             serial;
		logic [31:0]             st0;
		logic [31:0]             st1;
		logic [31:0]             ques;
		logic [31:0]             mcur;
		logic [31:0]             mvolt;
		logic [31:0]             mpwr;
		logic [OBJ_N-1:0][31:0]  obj;
		logic [TW-1:0]           tick;
		logic [15:0]             ms;
		logic                    dph;
		logic                    dwr;
		logic [7:0]              daddr;
		logic                    rdy;
		logic [31:0]             hrd;
		logic                    rv;
		logic                    ra;
		logic [31:0]             rd;
		cnl_area_t               area;
		logic                    lv;
		logic                    le;
		logic                    stp;
		logic                    frl;
		logic                    tx;
	} cnl_st_t;

	cnl_st_t s;
	cnl_st_t next_s;

	// ====================================================
	// helpers
	// bit timing index to data rate
	function automatic logic [9:0] kbps_of(input logic [3:0] b);
		case (b)
			4'h8:    kbps_of = 10'h00A; // 10 kbit/s
			4'h7:    kbps_of = 10'h014; // 20
			4'h6:    kbps_of = 10'h032; // 50
			4'h5:    kbps_of = 10'h064; // 100
			4'h4:    kbps_of = 10'h07D; // 125
			4'h3:    kbps_of = 10'h0FA; // 250
			4'h2:    kbps_of = 10'h1F4; // 500
			4'h1:    kbps_of = 10'h320; // 800
			4'h0:    kbps_of = 10'h3E8; // 1000
			default: kbps_of = 10'h000;
		endcase
	endfunction

	// dictionary area of an index
	function automatic cnl_area_t area_of(input logic [15:0] x);
		if (x >= A_RSV_LO)
			area_of = AR_RSV;
		else if (x >= A_IFC_LO)
			area_of = AR_IFC;
		else if (x >= A_DEV_LO)
			area_of = AR_DEV;
		else if (x >= A_MFR_LO)
			area_of = AR_MFR;
		else if (x >= A_COM_LO)
			area_of = AR_COM;
		else if (x > A_TYP_HI)
			area_of = AR_RSV;
		else if (x >= A_TYP_LO)
			area_of = AR_TYP;
		else
			area_of = AR_RSV;
	endfunction

	// {hit, slot} of an index in an object table
	function automatic logic [5:0] slot_of(input logic [15:0] x, input logic [15:0] t [OBJ_N]);
		logic [5:0] f;
		f = '0;
		for (int i = 0; i < OBJ_N; i++) begin
			if (x != X_NONE && x == t[i])
				f = {1'b1, 5'(i)};
		end
		return f;
	endfunction

	// ====================================================
	// next state
	always_comb begin
		logic       ms_tick;
		logic       sdo_ok;
		logic       tx_ok;
		logic       lock;
		logic [5:0] ws;
		logic [5:0] rs;
		logic [31:0] rdv;
		ms_tick = 1'b0;
		sdo_ok = 1'b0;
		tx_ok = 1'b0;
		lock = 1'b0;
		ws = '0;
		rs = '0;
		rdv = '0;
		next_s = s;
		next_s.rv = 1'b0;
		next_s.ra = 1'b0; // abort flag lives only with its answer
		next_s.lv = 1'b0;
		next_s.le = 1'b0;
		next_s.stp = 1'b0;
		next_s.frl = 1'b0;
		next_s.tx = 1'b0;
		next_s.rdy = 1'b1;

		// network state; lss state never alters it
		if (s.nmt == N_INIT)
			next_s.nmt = N_PREOP; // boot-up finishes in one cycle
		if (nmt_valid) begin
			case (nmt_cmd)
				NC_START: next_s.nmt = N_OPER;
				NC_STOP:  next_s.nmt = N_STOP;
				NC_PREOP: next_s.nmt = N_PREOP;
				default:  next_s.nmt = N_INIT;
			endcase
		end

		// layer setting services
		if (lss_valid) begin
			case (lss_cmd)
				L_SW_GLOBAL: begin
					next_s.cfg = lss_arg[0];
					if (!lss_arg[0]) begin // back to waiting, pending values go live
						next_s.id = s.pid;
						next_s.bt = s.pbt;
					end
				end
				L_SW_SEL: begin
					if (lss_vendor == VENDOR_ID && lss_product == PRODUCT_CODE &&
						lss_revision == REVISION && lss_serial == s.serial)
						next_s.cfg = 1'b1;
				end
				L_CFG_ID: begin
					if (s.cfg) begin
						next_s.lv = 1'b1;
						if (lss_arg >= ID_MIN && lss_arg <= ID_MAX)
							next_s.pid = lss_arg[6:0];
						else
							next_s.le = 1'b1;
					end
				end
				L_CFG_BIT: begin
					if (s.cfg) begin
						next_s.lv = 1'b1;
						if (lss_arg[7:4] == 4'h0 && lss_arg[3:0] <= BT_MAX)
							next_s.pbt = lss_arg[3:0];
						else
							next_s.le = 1'b1;
					end
				end
				L_STORE: begin
					if (s.cfg) begin // persist pending settings
						next_s.lv = 1'b1;
						next_s.nid = s.pid;
						next_s.nbt = s.pbt;
						next_s.stp = 1'b1;
					end
				end
				default: next_s.le = 1'b0;
			endcase
		end

		// bus write data phase
		if (s.dph && s.dwr) begin
			case (s.daddr)
				R_TTYPE:  next_s.ttype = hwdata[7:0];
				R_EVT:    next_s.evt = hwdata[15:0];
				R_SERIAL: next_s.serial = hwdata;
				R_ST0:    next_s.st0 = hwdata;
				R_ST1:    next_s.st1 = hwdata;
				R_QUES:   next_s.ques = hwdata;
				R_MCUR:   next_s.mcur = hwdata;
				R_MVOLT:  next_s.mvolt = hwdata;
				R_MPWR:   next_s.mpwr = hwdata;
				default:  next_s.dph = 1'b0;
			endcase
		end

		// bus address phase; read data is ready for the data phase
		case (haddr[7:0])
			R_TTYPE:  rdv = {24'h000000, s.ttype};
			R_EVT:    rdv = {16'h0000, s.evt};
			R_SERIAL: rdv = s.serial;
			R_ST0:    rdv = s.st0;
			R_ST1:    rdv = s.st1;
			R_QUES:   rdv = s.ques;
			R_MCUR:   rdv = s.mcur;
			R_MVOLT:  rdv = s.mvolt;
			R_MPWR:   rdv = s.mpwr;
			R_INFO: begin
				rdv[F_NMT +: 2] = s.nmt;
				rdv[F_CFG] = s.cfg;
				rdv[F_BT +: 4] = s.bt;
				rdv[F_ID +: 7] = s.id;
			end
			default:  rdv = '0;
		endcase
		next_s.dph = hsel && hready && htrans[1];
		next_s.dwr = hwrite;
		next_s.daddr = haddr[7:0];
		next_s.hrd = (hsel && hready && htrans[1] && !hwrite) ? rdv : '0;

		// service object access
		sdo_ok = (s.nmt == N_PREOP) || (s.nmt == N_OPER);
		lock = s.obj[S_LOCK][0];
		ws = slot_of(sdo_index, W_IDX);
		rs = slot_of(sdo_index, R_IDX);
		if (sdo_valid && sdo_ok) begin
			next_s.rv = 1'b1;
			next_s.ra = 1'b1; // abort unless an object claims it
			next_s.rd = '0;
			next_s.area = area_of(sdo_index);
			if (sdo_write) begin
				if (ws[5] && lock && int'(ws[4:0]) != S_LOCK)
					next_s.ra = 1'b1;
				else if (ws[5] && int'(ws[4:0]) == S_FACT) begin
					next_s.obj = '0;
					next_s.nid = DEF_ID;
					next_s.nbt = DEF_BT;
					next_s.frl = 1'b1;
					next_s.ra = 1'b0;
				end else if (ws[5]) begin
					next_s.obj[ws[4:0]] = sdo_wdata;
					next_s.ra = 1'b0;
				end else if (sdo_index == X_TPC && !lock) begin
					if (sdo_sub == SUB_TT) begin
						next_s.ttype = sdo_wdata[7:0];
						next_s.ra = 1'b0;
					end else if (sdo_sub == SUB_EVT) begin
						next_s.evt = sdo_wdata[15:0];
						next_s.ra = 1'b0;
					end
				end
			end else if (rs[5]) begin
				next_s.rd = s.obj[rs[4:0]];
				next_s.ra = 1'b0;
			end else begin
				next_s.ra = 1'b0;
				case (sdo_index)
					X_QUES:  next_s.rd = s.ques;
					X_MCUR:  next_s.rd = s.mcur;
					X_MVOLT: next_s.rd = s.mvolt;
					X_MPWR:  next_s.rd = s.mpwr;
					X_STAT: begin
						if (sdo_sub == SUB_ST0)
							next_s.rd = s.st0;
						else if (sdo_sub == SUB_ST1)
							next_s.rd = s.st1;
						else
							next_s.ra = 1'b1;
					end
					X_TPC: begin
						if (sdo_sub == SUB_TT)
							next_s.rd = {24'h000000, s.ttype};
						else if (sdo_sub == SUB_EVT)
							next_s.rd = {16'h0000, s.evt};
						else
							next_s.ra = 1'b1;
					end
					default: next_s.ra = 1'b1;
				endcase
			end
		end

		// millisecond divider and transmit pdo timing
		if (s.tick == TW'(MS_CYCLES - 1)) begin
			next_s.tick = '0;
			ms_tick = 1'b1;
		end else
			next_s.tick = s.tick + TW'(1);
		tx_ok = (s.nmt == N_OPER);
		if (tx_ok && s.ttype == TT_SYNC && sync_pulse)
			next_s.tx = 1'b1;
		if (tx_ok && s.ttype == TT_EVENT) begin
			if (event_pulse)
				next_s.tx = 1'b1;
			else if (ms_tick && s.evt != 16'h0000 && 17'(s.ms) + 17'h00001 >= 17'(s.evt))
				next_s.tx = 1'b1;
		end
		if (next_s.tx)
			next_s.ms = '0;
		else if (ms_tick && s.ms != 16'hFFFF)
			next_s.ms = s.ms + 16'h0001;

		next_s.kbps = kbps_of(next_s.bt);
	end

	// ====================================================
	// state register; factory values after reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.id <= DEF_ID;
			s.pid <= DEF_ID;
			s.nid <= DEF_ID;
			s.bt <= DEF_BT;
			s.pbt <= DEF_BT;
			s.nbt <= DEF_BT;
			s.kbps <= 10'h00A;
			s.rdy <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from the state register
	assign hreadyout = s.rdy;
	assign hresp = 1'b0 & s.rdy;
	assign hrdata = s.hrd;
	assign sdo_resp_valid = s.rv;
	assign sdo_resp_abort = s.ra;
	assign sdo_rdata = s.rd;
	assign sdo_area = s.area;
	assign lss_resp_valid = s.lv;
	assign lss_resp_err = s.le;
	assign lss_config = s.cfg;
	assign nmt_state = s.nmt;
	assign node_id = s.id;
	assign bit_timing = s.bt;
	assign bit_rate_kbps = s.kbps;
	assign store_pulse = s.stp;
	assign factory_reload = s.frl;
	assign tpdo_send = s.tx;
	assign output_on = s.obj[S_OUT][0];

	// ====================================================
	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence seq_sel_miss;
		lss_valid && lss_cmd == L_SW_SEL && lss_serial != s.serial && !s.cfg;
	endsequence
	sequence seq_bad_id;
		lss_valid && lss_cmd == L_CFG_ID && s.cfg && (lss_arg == 8'h00 || lss_arg > 8'h7F);
	endsequence
	sequence seq_store;
		lss_valid && lss_cmd == L_STORE && s.cfg;
	endsequence
	sequence seq_to_wait;
		lss_valid && lss_cmd == L_SW_GLOBAL && !lss_arg[0];
	endsequence
	sequence seq_locked_wr;
		sdo_valid && sdo_write && sdo_index == 16'h2201 && s.obj[S_LOCK][0] &&
			(s.nmt == N_PREOP || s.nmt == N_OPER);
	endsequence

	chk_sel_mismatch: assert property (seq_sel_miss |=> !lss_config)
		else $error("selective switch entered configuration on mismatch");
	chk_global_cfg: assert property (
		lss_valid && lss_cmd == L_SW_GLOBAL && lss_arg[0] |=> lss_config)
		else $error("global switch did not enter configuration");
	chk_pend_cfg: assert property (!$stable(s.pid) |-> $past(s.cfg))
		else $error("node id changed outside configuration");
	chk_id_range: assert property (seq_bad_id |=> lss_resp_valid && lss_resp_err)
		else $error("out of range node id not refused");
	chk_rate_fast: assert property (bit_timing == 4'h0 |-> bit_rate_kbps == 10'h3E8)
		else $error("bit timing 0 not decoded as 1 Mbit/s");
	chk_store_wait: assert property (
		seq_store ##1 !lss_valid ##1 seq_to_wait |=>
		store_pulse == 1'b0 && !lss_config && node_id == $past(s.nid))
		else $error("stored id not taken on return to waiting");
	chk_sync_tpdo: assert property (
		sync_pulse && s.ttype == 8'h01 && s.nmt == N_OPER |=> tpdo_send)
		else $error("sync did not trigger tpdo");
	chk_tpdo_state: assert property (tpdo_send |-> $past(s.nmt) == N_OPER)
		else $error("tpdo sent outside operational");
	chk_sdo_state: assert property (
		sdo_resp_valid |-> $past(s.nmt) == N_PREOP || $past(s.nmt) == N_OPER)
		else $error("sdo answered outside preop or operational");
	chk_lock_refuse: assert property (
		seq_locked_wr |=> sdo_resp_abort && $stable(s.obj[S_CUR]))
		else $error("locked node accepted a set-point write");
	chk_status_sub: assert property (
		sdo_valid && !sdo_write && sdo_index == 16'h200D && sdo_sub == 8'h02 &&
		(s.nmt == N_PREOP || s.nmt == N_OPER) |=> sdo_rdata == $past(s.st1) && !sdo_resp_abort)
		else $error("status sub 2 did not return word one");
	chk_ro_abort: assert property (
		sdo_valid && sdo_write && sdo_index == 16'h2101 && (s.nmt == N_PREOP || s.nmt == N_OPER)
		|=> sdo_resp_valid && sdo_resp_abort)
		else $error("write to read-only object not aborted");
endmodule

// File: testbench/cnl_master.sv
// cnl_master: canopen and lss master model driving decoded frame strobes
// assumes the node answers on the edge after each strobe
`timescale 1ns/1ps
module cnl_master #(
	parameter logic [31:0] VID = 32'h0,
	parameter logic [31:0] PID = 32'h0,
	parameter logic [31:0] RID = 32'h0
) (
	input  wire logic        hclk,
	output logic             nmt_valid,
	output logic [1:0]       nmt_cmd,
	output logic             lss_valid,
	output cnl_pkg::cnl_lss_t lss_cmd,
	output logic [7:0]       lss_arg,
	output logic [31:0]      lss_vendor,
	output logic [31:0]      lss_product,
	output logic [31:0]      lss_revision,
	output logic [31:0]      lss_serial,
	output logic             sdo_valid,
	output logic             sdo_write,
	output logic [15:0]      sdo_index,
	output logic [7:0]       sdo_sub,
	output logic [31:0]      sdo_wdata,
	output logic             sync_pulse,
	output logic             event_pulse
);
	import cnl_pkg::*;
	// ====================================================
	// idle levels; identity always carried whole
	initial begin
		{nmt_valid, lss_valid, sdo_valid, sync_pulse, event_pulse} = '0;
		{nmt_cmd, lss_arg, sdo_write, sdo_index, sdo_sub, sdo_wdata, lss_serial} = '0;
		lss_cmd = L_STORE;
		{lss_vendor, lss_product, lss_revision} = {VID, PID, RID};
	end
	// network command strobe
	task automatic nmt(input logic [1:0] c);
		@(posedge hclk);
		nmt_valid <= 1'b1;
		nmt_cmd <= c;
		@(posedge hclk);
		nmt_valid <= 1'b0;
		nmt_cmd <= ~c;
		#1;
	endtask
	// lss request; one node only on this bus
	task automatic lss(input cnl_lss_t c, input logic [7:0] a, input logic [31:0] s);
		@(posedge hclk);
		lss_valid <= 1'b1;
		lss_cmd <= c;
		lss_arg <= a;
		lss_serial <= s;
		@(posedge hclk);
		lss_valid <= 1'b0;
		lss_arg <= ~a;
		lss_serial <= ~s;
		#1;
	endtask
	// service object request; data scrambled once released
	task automatic sdo(input logic w, input logic [15:0] i, input logic [7:0] s,
		input logic [31:0] v);
		@(posedge hclk);
		{sdo_valid, sdo_write, sdo_index, sdo_sub, sdo_wdata} <= {1'b1, w, i, s, v};
		@(posedge hclk);
		{sdo_valid, sdo_index, sdo_wdata} <= {1'b0, ~i, ~v};
		#1;
	endtask
	// sync (s=1) or internal event strobe
	task automatic ev(input logic s);
		@(posedge hclk);
		{sync_pulse, event_pulse} <= {s, ~s};
		@(posedge hclk);
		{sync_pulse, event_pulse} <= 2'b00;
		#1;
	endtask
endmodule

// File: testbench/tb_canopen_node_lss_object_access.sv
// tb_canopen_node_lss_object_access: self-checking bench of the node
// assumes cnl_pkg, cnl_node and cnl_master are compiled first
`timescale 1ns/1ps
module tb_canopen_node_lss_object_access;
	import cnl_pkg::*;
	localparam int MSC = 10;
	localparam logic [31:0] VID = 32'h0000_5A11; // arbitrary value
	localparam logic [31:0] PID = 32'h0000_5B22; // arbitrary value
	localparam logic [31:0] RID = 32'h0000_5C33; // arbitrary value
	localparam logic [31:0] SER = 32'h1234_5678;
	localparam logic [15:0] AI [14] = '{16'h0000, 16'h0001, 16'h025F, 16'h0260, 16'h1000,
		16'h1FFF, 16'h2000, 16'h5FFF, 16'h6000, 16'h9FFF, 16'hA000, 16'hBFFF, 16'hC000, 16'hFFFF};
	localparam int AE [14] = '{0, 1, 1, 0, 2, 2, 3, 3, 4, 4, 5, 5, 0, 0};
	localparam int RT [9] = '{1000, 800, 500, 250, 125, 100, 50, 20, 10};
	localparam logic [7:0] SR [6] = '{R_ST0, R_ST1, R_QUES, R_MCUR, R_MVOLT, R_MPWR};
	localparam logic [15:0] SX [6] = '{X_STAT, X_STAT, X_QUES, X_MCUR, X_MVOLT, X_MPWR};
	localparam logic [7:0] SS [6] = '{SUB_ST0, SUB_ST1, 8'h00, 8'h00, 8'h00, 8'h00};
	logic        hclk, hresetn, hsel, hwrite, hresp, hreadyout;
	logic [1:0]  htrans, nmt_state, nmt_cmd;
	logic [2:0]  hsize, sdo_area;
	logic [31:0] haddr, hwdata, hrdata, sdo_rdata, q, d;
	logic        sdo_resp_valid, sdo_resp_abort, lss_resp_valid, lss_resp_err, lss_config;
	logic        store_pulse, factory_reload, tpdo_send, output_on;
	logic [6:0]  node_id;
	logic [3:0]  bit_timing;
	logic [9:0]  bit_rate_kbps;
	logic        nmt_valid, lss_valid, sdo_valid, sdo_write, sync_pulse, event_pulse;
	cnl_lss_t    lss_cmd;
	logic [7:0]  lss_arg, sdo_sub, idv;
	logic [15:0] sdo_index;
	logic [31:0] lss_vendor, lss_product, lss_revision, lss_serial, sdo_wdata;
	int          n_fail, checks_done, seed, cnt, mobj [OBJ_N];
	// ====================================================
	// design and master model
	cnl_node #(.VENDOR_ID(VID), .PRODUCT_CODE(PID), .REVISION(RID), .MS_CYCLES(MSC)) i_cnl_node (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
		.hreadyout, .hresp, .hrdata, .nmt_valid, .nmt_cmd, .lss_valid, .lss_cmd, .lss_arg,
		.lss_vendor, .lss_product, .lss_revision, .lss_serial, .sdo_valid, .sdo_write,
		.sdo_index, .sdo_sub, .sdo_wdata, .sync_pulse, .event_pulse, .sdo_resp_valid,
		.sdo_resp_abort, .sdo_rdata, .sdo_area, .lss_resp_valid, .lss_resp_err, .lss_config,
		.nmt_state, .node_id, .bit_timing, .bit_rate_kbps, .store_pulse, .factory_reload,
		.tpdo_send, .output_on);
	cnl_master #(.VID(VID), .PID(PID), .RID(RID)) i_cnl_master (.hclk, .nmt_valid, .nmt_cmd,
		.lss_valid, .lss_cmd, .lss_arg, .lss_vendor, .lss_product, .lss_revision, .lss_serial,
		.sdo_valid, .sdo_write, .sdo_index, .sdo_sub, .sdo_wdata, .sync_pulse, .event_pulse);
	// ====================================================
	// clock, watchdog and reporting
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	initial begin
		repeat (20000) @(posedge hclk);
		n_fail++;
		tally_and_finish();
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// single ahb-lite word transfer, waits on hready
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge hclk);
		{hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, v};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
		hwdata <= ~v;
	endtask
	// answered service access
	task automatic so(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] v);
		i_cnl_master.sdo(w, i, s, v);
		chk("sdo answer", sdo_resp_valid, 1);
	endtask
	// ====================================================
	// main sequence
	initial begin
		{hresetn, hsel, htrans, hwrite, haddr, hwdata} = '0;
		hsize = 3'h2;
		seed = 34555;
		mobj = '{default: 0};
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(posedge hclk);
		chk("node id", node_id, 32'h70);
		chk("rate", bit_rate_kbps, 10);
		ahb(1, R_SERIAL, SER);
		ahb(0, R_SERIAL, 0);
		chk("serial", q, SER);
		chk("okay", hresp, 0);
		// lss state changes and reconfiguration
		i_cnl_master.lss(L_CFG_ID, 8'h33, SER);
		chk("cfg refused", {lss_resp_valid, node_id}, 32'h70);
		i_cnl_master.lss(L_SW_SEL, 8'h0, SER ^ 32'h8000_0000);
		chk("sel mismatch", lss_config, 0);
		i_cnl_master.lss(L_SW_SEL, 8'h0, SER);
		chk("sel match", lss_config, 1);
		i_cnl_master.lss(L_SW_GLOBAL, 8'h0, SER);
		chk("waiting", lss_config, 0);
		i_cnl_master.lss(L_SW_GLOBAL, 8'h1, ~SER);
		chk("global cfg", lss_config, 1);
		i_cnl_master.lss(L_CFG_ID, 8'h80, SER);
		chk("id range", {lss_resp_valid, lss_resp_err}, 2'b11);
		for (int t = 0; t < 9; t++) begin
			i_cnl_master.lss(L_CFG_BIT, 8'(t), SER);
			i_cnl_master.lss(L_SW_GLOBAL, 8'h0, SER);
			chk("bit rate", {bit_timing, bit_rate_kbps}, {4'(t), 10'(RT[t])});
			i_cnl_master.lss(L_SW_GLOBAL, 8'h1, SER);
		end
		i_cnl_master.lss(L_CFG_BIT, 8'h09, SER);
		chk("bit range", {lss_resp_valid, lss_resp_err}, 2'b11);
		idv = 8'($unsigned($random(seed)) % 127 + 1);
		i_cnl_master.lss(L_CFG_ID, idv, SER);
		chk("id ok", {lss_resp_valid, lss_resp_err}, 2'b10);
		i_cnl_master.lss(L_STORE, 8'h0, SER);
		chk("store", store_pulse, 1);
		i_cnl_master.lss(L_SW_GLOBAL, 8'h0, SER);
		chk("new id", node_id, idv);
		ahb(0, R_INFO, 0);
		chk("info", q, {idv, 8'h81});
		ahb(0, 8'h30, 0);
		chk("unmapped", q, 0);
		// dictionary area decode, unknown index aborts
		foreach (AI[k]) begin
			so(0, AI[k], 8'h0, 0);
			chk("area", {sdo_resp_abort, sdo_area}, {1'b1, 3'(AE[k])});
		end
		// write/read object pairs against the model
		for (int k = 0; k < S_FACT; k++) begin
			d = $random(seed);
			if (k == S_LOCK) d[0] = 1'b0;
			so(1, W_IDX[k], 8'h0, d);
			mobj[k] = d;
			so(0, R_IDX[k], 8'h0, 0);
			chk("pair", sdo_rdata, mobj[k]);
		end
		chk("output", output_on, mobj[S_OUT] & 1);
		// read-only status and measurements
		foreach (SR[k]) begin
			d = $random(seed);
			ahb(1, SR[k], d);
			so(0, SX[k], SS[k], 0);
			chk("status", sdo_rdata, d);
			so(1, SX[k], SS[k], d);
			chk("ro write", sdo_resp_abort, 1);
		end
		// lock refuses set-point change
		so(1, W_IDX[S_LOCK], 8'h0, 1);
		so(1, W_IDX[S_CUR], 8'h0, 32'h55);
		chk("locked", sdo_resp_abort, 1);
		so(0, R_IDX[S_LOCK], 8'h0, 0);
		chk("lock rd", sdo_rdata, 1);
		// factory reload clears objects; unlock first, a locked node refuses it
		so(1, W_IDX[S_LOCK], 8'h0, 0);
		chk("unlock", sdo_resp_abort, 0);
		so(0, W_IDX[S_FACT], 8'h0, 0);
		chk("fact rd", sdo_resp_abort, 1);
		so(1, W_IDX[S_FACT], 8'h0, 0);
		chk("reload", factory_reload, 1);
		so(0, R_IDX[S_CUR], 8'h0, 0);
		chk("cleared", sdo_rdata, 0);
		// pdo transmission types
		ahb(1, R_TTYPE, {24'h0, TT_SYNC});
		i_cnl_master.ev(1);
		chk("preop pdo", tpdo_send, 0);
		i_cnl_master.nmt(NC_START);
		chk("oper", nmt_state, N_OPER);
		i_cnl_master.ev(1);
		chk("sync pdo", tpdo_send, 1);
		ahb(1, R_TTYPE, {24'h0, TT_EVENT});
		ahb(1, R_EVT, 2);
		so(0, X_TPC, SUB_TT, 0);
		chk("type obj", sdo_rdata, TT_EVENT);
		i_cnl_master.ev(0);
		chk("event pdo", tpdo_send, 1);
		cnt = 0;
		repeat (100) begin
			@(posedge hclk);
			#1;
			cnt += int'(tpdo_send === 1'b1);
		end
		chk("timer pdo", cnt inside {4, 5}, 1);
		i_cnl_master.nmt(NC_STOP);
		i_cnl_master.sdo(0, R_IDX[S_CUR], 8'h0, 0);
		chk("stopped", sdo_resp_valid, 0);
		i_cnl_master.nmt(NC_PREOP);
		chk("preop", nmt_state, N_PREOP);
		i_cnl_master.nmt(NC_RESET);
		chk("reset cmd", nmt_state, N_INIT);
		so(0, R_IDX[S_CUR], 8'h0, 0);
		chk("after boot", sdo_resp_abort, 0);
		tally_and_finish();
	end
endmodule
